// [include/adc_seq_regs.svh]
// Register map, field positions, reset values and timing counts of the
// conversion sequencer. Assumes a 32-bit APB bus with word-aligned registers.
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CONV_CTRL_REG_A 8'h00
`define OFS_CONV_CTRL_REG_B 8'h04
`define OFS_RESULT_REG_HIGH 8'h08
`define OFS_RESULT_REG_LOW_STATUS 8'h0c
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_CONV_START 7
`define BIT_MODE_HI 6
`define BIT_MODE_LO 5
`define BIT_AIN_DISABLE 4
`define BIT_CHAN_HI 3
`define BIT_CHAN_LO 0
`define BIT_LADDER_REF 5
`define BIT_TSEL_HI 3
`define BIT_TSEL_LO 1
`define BIT_DONE 5
`define BIT_BUSY 4
`define BIT_IRQ_DONE 0

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_CHAN 4'h0
`define RST_AIN_DISABLE 1'h0
`define RST_TSEL 3'h0
`define RST_LADDER 1'h0
`define RST_RESULT 10'h000
`define RST_MASK 1'h0

// ****************************************************************
// Conversion times in high-frequency clock cycles
// ****************************************************************
`define TSEL_39 3'h0
`define TSEL_78 3'h2
`define TSEL_156 3'h3
`define TSEL_312 3'h4
`define TSEL_624 3'h5
`define TSEL_1248 3'h6
`define CONV_CLKS_39 11'h027
`define CONV_CLKS_78 11'h04e
`define CONV_CLKS_156 11'h09c
`define CONV_CLKS_312 11'h138
`define CONV_CLKS_624 11'h270
`define CONV_CLKS_1248 11'h4e0
`define CNT_ONE 11'h001
`define CNT_ZERO 11'h000

`endif

// [include/adc_seq_pkg.sv]
// Types used only by the conversion sequencer, not by its bench.
// Assumes adc_seq_regs.svh supplies all numeric constants.
package adc_seq_pkg;
  // Operating mode field encoding
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_SOFT = 2'b01,
    MODE_RSVD = 2'b10,
    MODE_REPEAT = 2'b11
  } op_mode_e;

  // Sequencer state
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } conv_state_e;

  // One APB request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } apb_req_s;

  // Control register A contents
  typedef struct packed {
    op_mode_e mode;
    logic ain_disable;
    logic [3:0] chan;
  } ctrl_a_s;
endpackage

// [hw/adc_conversion_sequencer.sv]
// Conversion sequencer for a 10-bit successive-approximation converter,
// with APB register access, completion interrupt and standby handling.
// Assumes the analog front end delivers its code on adc_code_in and that
// standby_in comes from the power controller in another clock domain.
//
// Contract
// - Software-start mode plus start write begins one conversion of selected channel
// - Completion loads result, sets done flag and pulses done interrupt together
// - Start bit clears itself once the conversion has begun
// - Repeat mode plus start write begins continuous conversion
// - Repeat mode restarts automatically after each completed conversion
// - Writing disable mode halts repeat conversion immediately
// - An aborted conversion never reaches the result registers
// - Reading the conversion result clears the done flag
// - New start clears done flag; old result stays until new completion
// - Standby aborts conversion, resets both control registers, loses results
// - After standby nothing restarts; software reprograms and starts again
// - Reference ladder is disconnected during standby
// - Result is 10 bits split into high and low result registers
// - Busy flag set during conversion, cleared at finish or standby entry
//
// The APB register port and the placing of the registers were left to the implementer.
`include "adc_seq_regs.svh"

module adc_conversion_sequencer (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic standby_in,
  input wire logic [9:0] adc_code_in,
  output logic [3:0] channel_out,
  output logic analog_input_disable_out,
  output logic sample_en_out,
  output logic ladder_on_out,
  output logic conv_done_irq_out,
  output logic irq_out
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Terminal count for a time select code; reserved codes take the longest
  // time so a bad setting can only slow the converter down, never rush it
  function automatic logic [10:0] conv_clks(input logic [2:0] tsel);
    case (tsel)
      `TSEL_39: conv_clks = `CONV_CLKS_39;
      `TSEL_78: conv_clks = `CONV_CLKS_78;
      `TSEL_156: conv_clks = `CONV_CLKS_156;
      `TSEL_312: conv_clks = `CONV_CLKS_312;
      `TSEL_624: conv_clks = `CONV_CLKS_624;
      `TSEL_1248: conv_clks = `CONV_CLKS_1248;
      default: conv_clks = `CONV_CLKS_1248;
    endcase
  endfunction

  // Register address match
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  adc_seq_pkg::apb_req_s req;
  adc_seq_pkg::ctrl_a_s ctrl_q;
  adc_seq_pkg::ctrl_a_s wr_ctrl;
  adc_seq_pkg::conv_state_e state_q;
  logic pready_q;
  logic [31:0] rdata_d;
  logic mapped;
  logic wr_en;
  logic rd_en;
  logic wr_a;
  logic start_q;
  logic [2:0] tsel_q;
  logic ladder_q;
  logic standby_meta_q;
  logic standby_q;
  logic [9:0] code_meta_q;
  logic [9:0] code_q;
  logic [10:0] count_q;
  logic [10:0] term_q;
  logic [9:0] result_q;
  logic done_q;
  logic irq_stat_q;
  logic irq_mask_q;
  logic start_req;
  logic disable_wr;
  logic conv_end;
  logic result_ok;
  logic read_high;

  // ****************************************************************
  // APB decode
  // ****************************************************************

  // Bundle the bus request; writes and reads act only in the ready cycle
  assign req = '{psel_in, penable_in, pwrite_in, paddr_in, pwdata_in};
  assign wr_en = req.sel & req.enable & req.write & pready_q;
  assign rd_en = req.sel & req.enable & ~req.write & pready_q;
  assign mapped = hit(req.addr, `OFS_CONV_CTRL_REG_A) | hit(req.addr, `OFS_CONV_CTRL_REG_B)
                | hit(req.addr, `OFS_RESULT_REG_HIGH) | hit(req.addr, `OFS_RESULT_REG_LOW_STATUS)
                | hit(req.addr, `OFS_IRQ_STATUS) | hit(req.addr, `OFS_IRQ_MASK);
  // Control registers accept no writes while standby holds them in reset
  assign wr_a = wr_en & hit(req.addr, `OFS_CONV_CTRL_REG_A) & ~standby_q;
  assign wr_ctrl = req.wdata[`BIT_MODE_HI:`BIT_CHAN_LO];
  assign read_high = rd_en & hit(req.addr, `OFS_RESULT_REG_HIGH);

  // ****************************************************************
  // Sequencer events
  // ****************************************************************

  // Start only in the two valid modes, using the mode written alongside
  assign start_req = wr_a & req.wdata[`BIT_CONV_START]
                   & ((wr_ctrl.mode == adc_seq_pkg::MODE_SOFT)
                   | (wr_ctrl.mode == adc_seq_pkg::MODE_REPEAT));
  assign disable_wr = wr_a & (wr_ctrl.mode == adc_seq_pkg::MODE_OFF);
  assign conv_end = (state_q == adc_seq_pkg::ST_CONV) & (count_q == term_q - `CNT_ONE);
  // A conversion cut short by disable or standby stores nothing
  assign result_ok = conv_end & ~disable_wr & ~standby_q & ~start_req;

  // Two-flop synchronisers for the standby level and the analog code
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      standby_meta_q <= 1'b0;
      standby_q <= 1'b0;
      code_meta_q <= `RST_RESULT;
      code_q <= `RST_RESULT;
    end else begin
      standby_meta_q <= standby_in;
      standby_q <= standby_meta_q;
      code_meta_q <= adc_code_in;
      code_q <= code_meta_q;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************

  // Control register A; standby forces the initial values
  always_ff @(posedge clk_in) begin
    if (reset_in || standby_q) begin
      ctrl_q <= '{adc_seq_pkg::MODE_OFF, `RST_AIN_DISABLE, `RST_CHAN};
    end else if (wr_a) begin
      ctrl_q <= wr_ctrl;
    end
  end

  // Start bit is held for one cycle only, so it reads back as zero
  always_ff @(posedge clk_in) begin
    if (reset_in || standby_q) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_req;
    end
  end

  // Control register B: time select and ladder control
  always_ff @(posedge clk_in) begin
    if (reset_in || standby_q) begin
      tsel_q <= `RST_TSEL;
      ladder_q <= `RST_LADDER;
    end else if (wr_en && hit(req.addr, `OFS_CONV_CTRL_REG_B)) begin
      tsel_q <= req.wdata[`BIT_TSEL_HI:`BIT_TSEL_LO];
      ladder_q <= req.wdata[`BIT_LADDER_REF];
    end
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************

  // State and busy: a start (even a forbidden restart) reloads the timer;
  // repeat mode chains the next conversion from the completing cycle
  always_ff @(posedge clk_in) begin
    if (reset_in || standby_q) begin
      state_q <= adc_seq_pkg::ST_IDLE;
    end else if (disable_wr) begin
      state_q <= adc_seq_pkg::ST_IDLE;
    end else if (start_req) begin
      state_q <= adc_seq_pkg::ST_CONV;
    end else begin
      case (state_q)
        adc_seq_pkg::ST_IDLE: state_q <= adc_seq_pkg::ST_IDLE;
        adc_seq_pkg::ST_CONV: begin
          if (conv_end && ctrl_q.mode != adc_seq_pkg::MODE_REPEAT) begin
            state_q <= adc_seq_pkg::ST_IDLE;
          end
        end
        default: state_q <= adc_seq_pkg::ST_IDLE;
      endcase
    end
  end

  // Conversion timer; term is latched at start so a mid-run change of the
  // time select cannot shorten the conversion in progress
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      count_q <= `CNT_ZERO;
      term_q <= `CONV_CLKS_1248;
    end else if (start_req) begin
      count_q <= `CNT_ZERO;
      term_q <= conv_clks(tsel_q);
    end else if (conv_end) begin
      count_q <= `CNT_ZERO;
    end else if (state_q == adc_seq_pkg::ST_CONV) begin
      count_q <= count_q + `CNT_ONE;
    end
  end

  // Result store; standby wipes earlier results
  always_ff @(posedge clk_in) begin
    if (reset_in || standby_q) begin
      result_q <= `RST_RESULT;
    end else if (result_ok) begin
      result_q <= code_q;
    end
  end

  // Done flag: completion wins over a clearing read in the same cycle
  always_ff @(posedge clk_in) begin
    if (reset_in || standby_q) begin
      done_q <= 1'b0;
    end else if (result_ok) begin
      done_q <= 1'b1;
    end else if (start_req || read_high) begin
      done_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_stat_q <= 1'b0;
    end else if (result_ok) begin
      irq_stat_q <= 1'b1;
    end else if (wr_en && hit(req.addr, `OFS_IRQ_STATUS) && req.wdata[`BIT_IRQ_DONE]) begin
      irq_stat_q <= 1'b0;
    end
  end

  // Mask register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_mask_q <= `RST_MASK;
    end else if (wr_en && hit(req.addr, `OFS_IRQ_MASK)) begin
      irq_mask_q <= req.wdata[`BIT_IRQ_DONE];
    end
  end

  // Interrupt outputs: pulse aligned with the result load, plus masked level
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      conv_done_irq_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      conv_done_irq_out <= result_ok;
      irq_out <= (irq_stat_q | result_ok) & irq_mask_q;
    end
  end

  // ****************************************************************
  // Analog front-end controls
  // ****************************************************************

  // Ladder follows its enable or a running conversion, never in standby
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      channel_out <= `RST_CHAN;
      analog_input_disable_out <= `RST_AIN_DISABLE;
      sample_en_out <= 1'b0;
      ladder_on_out <= 1'b0;
    end else begin
      channel_out <= ctrl_q.chan;
      analog_input_disable_out <= ctrl_q.ain_disable;
      sample_en_out <= (state_q == adc_seq_pkg::ST_CONV) & ~standby_q;
      ladder_on_out <= (ladder_q | (state_q == adc_seq_pkg::ST_CONV)) & ~standby_q;
    end
  end

  // ****************************************************************
  // APB read path and handshake
  // ****************************************************************

  // Read data mux; unused bits read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit(req.addr, `OFS_CONV_CTRL_REG_A)) begin
      rdata_d[`BIT_CONV_START] = start_q;
      rdata_d[`BIT_MODE_HI:`BIT_CHAN_LO] = ctrl_q;
    end else if (hit(req.addr, `OFS_CONV_CTRL_REG_B)) begin
      rdata_d[`BIT_LADDER_REF] = ladder_q;
      rdata_d[`BIT_TSEL_HI:`BIT_TSEL_LO] = tsel_q;
    end else if (hit(req.addr, `OFS_RESULT_REG_HIGH)) begin
      rdata_d[7:0] = result_q[9:2];
    end else if (hit(req.addr, `OFS_RESULT_REG_LOW_STATUS)) begin
      rdata_d[7:6] = result_q[1:0];
      rdata_d[`BIT_DONE] = done_q;
      rdata_d[`BIT_BUSY] = (state_q == adc_seq_pkg::ST_CONV);
    end else if (hit(req.addr, `OFS_IRQ_STATUS)) begin
      rdata_d[`BIT_IRQ_DONE] = irq_stat_q;
    end else if (hit(req.addr, `OFS_IRQ_MASK)) begin
      rdata_d[`BIT_IRQ_DONE] = irq_mask_q;
    end
  end

  // One wait state: ready rises in the second access cycle, with data
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pready_q <= 1'b0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_q <= req.sel & req.enable & ~pready_q;
      pready_out <= req.sel & req.enable & ~pready_q;
      pslverr_out <= req.sel & req.enable & ~pready_q & ~mapped;
      if (req.sel && req.enable && !pready_q && !req.write) begin
        prdata_out <= rdata_d;
      end
    end
  end

endmodule // adc_conversion_sequencer

// [test/adc_seq_props.sv]
// Checker for the conversion sequencer, watching its top-level ports only.
// Assumes one clock and APB requests held steady until pready_out.
`include "adc_seq_regs.svh"

module adc_seq_props (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic standby_in,
  input wire logic sample_en_out,
  input wire logic ladder_on_out,
  input wire logic conv_done_irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Helper logic and properties
  // ****************************************
  logic acc_w;
  logic start_w;
  logic [11:0] cnt_q;
  logic [2:0] tsel_q;
  assign acc_w = psel_in & penable_in & pready_out & pwrite_in;
  assign start_w = acc_w && paddr_in == `OFS_CONV_CTRL_REG_A && pwdata_in[7];

  // Cycles since a start; a repeat restart sits one cycle before its pulse
  always_ff @(posedge clk_in) begin
    if (start_w) begin
      cnt_q <= 12'h000;
    end else if (conv_done_irq_out) begin
      cnt_q <= 12'h001;
    end else begin
      cnt_q <= cnt_q + 12'h001;
    end
  end

  // Time select as last written; standby puts it back to reset
  always_ff @(posedge clk_in) begin
    if (reset_in || standby_in) begin
      tsel_q <= `RST_TSEL;
    end else if (acc_w && paddr_in == `OFS_CONV_CTRL_REG_B) begin
      tsel_q <= pwdata_in[`BIT_TSEL_HI:`BIT_TSEL_LO];
    end
  end

  function automatic logic [11:0] conv_len(input logic [2:0] t);
    case (t)
      `TSEL_39: return {1'b0, `CONV_CLKS_39};
      `TSEL_78: return {1'b0, `CONV_CLKS_78};
      `TSEL_156: return {1'b0, `CONV_CLKS_156};
      `TSEL_312: return {1'b0, `CONV_CLKS_312};
      `TSEL_624: return {1'b0, `CONV_CLKS_624};
      default: return {1'b0, `CONV_CLKS_1248};
    endcase
  endfunction

  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  property p_apb_wait; psel_in && !penable_in |=> !pready_out ##1 pready_out; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("APB answer timing wrong");
  property p_slverr; pready_out |-> pslverr_out == (paddr_in > `OFS_IRQ_MASK); endproperty
  a_slverr: assert property (p_slverr) else $error("slave error flag wrong");
  property p_start; start_w && pwdata_in[5] && !standby_in && !$past(standby_in)
    && !$past(standby_in, 2) && !$past(standby_in, 3) |-> ##2 sample_en_out; endproperty
  a_start: assert property (p_start) else $error("start did not begin a conversion");
  property p_len; conv_done_irq_out |-> cnt_q == conv_len(tsel_q); endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  property p_pulse; conv_done_irq_out |=> !conv_done_irq_out; endproperty
  a_pulse: assert property (p_pulse) else $error("done pulse too long");
  property p_halt; acc_w && paddr_in == `OFS_CONV_CTRL_REG_A && pwdata_in[6:5] == 2'b00
    |-> ##2 (!sample_en_out && !conv_done_irq_out) ##1 !conv_done_irq_out; endproperty
  a_halt: assert property (p_halt) else $error("disable did not halt");
  property p_ladder; standby_in [*3] |=> !ladder_on_out; endproperty
  a_ladder: assert property (p_ladder) else $error("ladder on in standby");
  property p_stby_busy; standby_in [*4] |=> !sample_en_out; endproperty
  a_stby_busy: assert property (p_stby_busy) else $error("busy in standby");
endmodule // adc_seq_props

bind adc_conversion_sequencer adc_seq_props props_u (.clk_in, .reset_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .pslverr_out,
  .standby_in, .sample_en_out, .ladder_on_out, .conv_done_irq_out);

// [test/adc_front_model.sv]
// Analog front end on the far side: a source level per selected channel.
// Assumes sample_en_in marks when the code must hold steady.
module adc_front_model (
  input wire logic clk_in,
  input wire logic [3:0] channel_in,
  input wire logic sample_en_in,
  input wire logic [9:0] level_in,
  output logic [9:0] code_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial code_out = 10'h000;
  // Steady while sampled; churns otherwise so a stale sample cannot pass
  always @(posedge clk_in) begin
    if (sample_en_in) begin
      code_out <= level_in ^ {6'h00, channel_in};
    end else begin
      code_out <= ~code_out;
    end
  end
endmodule // adc_front_model

// [test/adc_conversion_sequencer_test.sv]
// Self-checking bench for the conversion sequencer over APB.
// Assumes the checker is bound to the design and the front end is modelled.
module adc_conversion_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals, tasks and sequence
  // ****************************************
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_s;
  logic clk_in, reset_in, psel_in, penable_in, pwrite_in, standby_in;
  logic pready_out, pslverr_out, ain_off, sample_en_out, ladder_on_out, done_irq, irq_out;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic [3:0] channel_out, chan;
  logic [9:0] adc_code_in, level, c, c2;
  logic [2:0] tsl[7] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h1, 3'h0};
  note_s notes[$];
  int fail_count, samples_checked, cycles;
  integer seed;

  adc_conversion_sequencer dut_u (.clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .standby_in,
    .adc_code_in, .channel_out, .analog_input_disable_out(ain_off), .sample_en_out,
    .ladder_on_out, .conv_done_irq_out(done_irq), .irq_out);
  adc_front_model front_u (.clk_in, .channel_in(channel_out), .sample_en_in(sample_en_out),
    .level_in(level), .code_out(adc_code_in));

  // 50 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Ceiling well above the longest run of conversions
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("MISMATCH %0t timeout", $time);
      finish_test();
    end
  end

  task automatic check_resp(input note_s n, input logic [31:0] d, input logic e);
    samples_checked++;
    if ((d & n.m) !== (n.d & n.m) || e !== n.e) begin
      fail_count++;
      $display("MISMATCH %0t read %h want %h", $time, d, n.d);
    end
  endtask

  task automatic check_level(input logic g, input logic x);
    samples_checked++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH %0t level %b want %b", $time, g, x);
    end
  endtask

  // Every answer is held against the oldest queued expectation
  always @(posedge clk_in) begin
    if (pready_out === 1'b1) check_resp(notes.pop_front(), prdata_out, pslverr_out);
  end

  // One APB transfer; the request holds until pready is seen
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] x, input logic [31:0] m, input logic e);
    notes.push_back('{x, m, e});
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    // Only the bench timeout ends this wait
    @(posedge clk_in);
    while (pready_out !== 1'b1) @(posedge clk_in);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 32'h0, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    apb(a, 1'b0, 32'h0, x, m, 1'b0);
  endtask

  task automatic wait_irq();
    int n;
    @(negedge clk_in);
    for (n = 0; n < 1500 && irq_out !== 1'b1; n++) @(negedge clk_in);
    check_level(irq_out, 1'b1);
  endtask

  // Random level on the channel, mode first, then the start write
  task automatic start_conv(input logic [7:0] a, output logic [9:0] v);
    v = 10'($random(seed));
    level <= v;
    v = v ^ {6'h00, a[3:0]};
    wr(8'h00, {24'h0, a});
    wr(8'h00, {24'h0, a | 8'h80});
  endtask

  task automatic got_result(input logic [9:0] v);
    rd(8'h0c, {24'h0, v[1:0], 6'h20}, 32'hffff_fff0);
    rd(8'h08, {24'h0, v[9:2]}, 32'hffff_ffff);
    rd(8'h0c, {24'h0, v[1:0], 6'h00}, 32'hffff_fff0);
    rd(8'h10, 32'h1, 32'hffff_ffff);
    wr(8'h10, 32'h1);
    rd(8'h10, 32'h0, 32'hffff_ffff);
    @(negedge clk_in);
    check_level(irq_out, 1'b0);
  endtask

  initial begin
    seed = 32'h73898c71;
    {psel_in, penable_in, pwrite_in, standby_in} = 4'h0;
    {paddr_in, pwdata_in, level} = 50'h0;
    reset_in = 1'b1;
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 32'h0, 32'hffff_ffff);
    apb(8'h18, 1'b0, 32'h0, 32'h0, 32'h0, 1'b1);
    wr(8'h14, 32'h1);
    // Every valid time select plus reserved code 1; ends on the shortest
    foreach (tsl[i]) begin
      chan = 4'($unsigned($random(seed)) % 6);
      wr(8'h04, {26'h1, 2'b00, tsl[i], 1'b0});
      start_conv({3'b001, 1'b0, chan}, c);
      rd(8'h00, {25'h0, 2'b01, 1'b0, chan}, 32'hffff_ffff);
      rd(8'h0c, 32'h10, 32'h30);
      wait_irq();
      got_result(c);
    end
    // Restart before the result is read
    start_conv(8'h22, c);
    wait_irq();
    wr(8'h10, 32'h1);
    start_conv(8'h22, c2);
    rd(8'h0c, {24'h0, c[1:0], 6'h10}, 32'hf0);
    rd(8'h08, {24'h0, c[9:2]}, 32'hff);
    wait_irq();
    got_result(c2);
    // Masked completion stays quiet until unmasked
    wr(8'h14, 32'h0);
    start_conv(8'h24, c);
    repeat (60) @(negedge clk_in);
    check_level(irq_out, 1'b0);
    wr(8'h14, 32'h1);
    wait_irq();
    got_result(c);
    // Repeat mode, then a disable in mid-conversion
    start_conv(8'h63, c);
    wait_irq();
    wr(8'h10, 32'h1);
    wait_irq();
    rd(8'h08, {24'h0, c[9:2]}, 32'hff);
    wr(8'h10, 32'h1);
    level <= ~level;
    wr(8'h00, 32'h0);
    rd(8'h0c, {24'h0, c[1:0], 6'h00}, 32'hf0);
    rd(8'h08, {24'h0, c[9:2]}, 32'hff);
    // Analog input disable reaches its pin one cycle after the write lands
    wr(8'h00, 32'h10);
    repeat (2) @(negedge clk_in);
    check_level(ain_off, 1'b1);
    // Standby in mid-conversion; writes then are dropped
    wr(8'h04, 32'h20);
    start_conv(8'h21, c);
    @(negedge clk_in);
    check_level(ladder_on_out, 1'b1);
    @(posedge clk_in);
    standby_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    wr(8'h00, 32'ha1);
    @(negedge clk_in);
    check_level(ladder_on_out, 1'b0);
    check_level(sample_en_out, 1'b0);
    rd(8'h00, 32'h0, 32'hff);
    rd(8'h04, 32'h0, 32'hff);
    rd(8'h08, 32'h0, 32'hff);
    standby_in <= 1'b0;
    repeat (100) @(negedge clk_in);
    check_level(sample_en_out, 1'b0);
    finish_test();
  end
endmodule // adc_conversion_sequencer_test
